// *** common/sda_defines.svh ***
// Purpose: named constants of the slow-domain indirect access block
// Assumes: included by the package and by the design files
// Notes: definitions only
`ifndef SDA_DEFINES_SVH
`define SDA_DEFINES_SVH

// byte addresses of the three special function registers
`define SFR_DATA_HI 8'hab
`define SFR_DATA_LO 8'hac
`define SFR_CTRL 8'had

// reset values
`define DATA_RESET 8'h00
`define WDOG_INIT 16'hffff
`define RTC_INIT 24'h000000

// indirect addresses
`define IA_WDOG 3'h0
`define IA_RTC_UP 3'h1
`define IA_RTC_LO 3'h2
`define IA_RTC_CNT 3'h3
`define IA_WAKE_A 3'h4
`define IA_WAKE_B 3'h5

// debounce lengths in slow clock pulses
`define DEB_LEN0 7'h00
`define DEB_LEN1 7'h02
`define DEB_LEN2 7'h08
`define DEB_LEN3 7'h40
`define DEB_MAX 7'h7f

// edge codes
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// tick = (1 + divider) slow clock periods
`define TICK_DIV 8'h03

`endif

// *** common/sda_pkg.sv ***
// Purpose: types and helper functions of the slow-domain indirect access block
// Assumes: sda_defines.svh on the include path
// Notes: no module here
`include "sda_defines.svh"

package sda_pkg;

	typedef struct packed
	{
		logic [1:0] edgeSel;
		logic [1:0] debSel;
	} pin_cfg_type;

	typedef struct packed
	{
		logic dir;
		logic [2:0] addr;
	} ctrl_type;

	typedef enum logic {CMD_IDLE, CMD_PENDING} cmd_state_type;

	function automatic logic [6:0] debounce_len(input logic [1:0] code);
		logic [6:0] len;
		len = `DEB_LEN0;
		case (code)
			2'h1: len = `DEB_LEN1;
			2'h2: len = `DEB_LEN2;
			2'h3: len = `DEB_LEN3;
			default: len = `DEB_LEN0;
		endcase
		return len;
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		logic hit;
		hit = 1'b0;
		case (sel)
			`EDGE_RISE: hit = !prev && cur;
			`EDGE_FALL: hit = prev && !cur;
			`EDGE_BOTH: hit = prev != cur;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

endpackage

// *** rtl/sync_two_flop.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to clock
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(parameter int WIDTH = 1)
(
	input wire logic clock, // system clock
	input wire logic rstn, // synchronised reset, active low
	input wire logic clockEnable, // freezes state when low
	input wire logic [WIDTH-1:0] asyncIn, // raw pins
	output logic [WIDTH-1:0] syncOut // synchronised copy
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= '0;
			syncOut <= '0;
		end
		else if (clockEnable)
		begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end

endmodule

`default_nettype wire

// *** rtl/pin_wakeup_filter.sv ***
// Purpose: debounce and edge detection of one wakeup pin
// Assumes: pinLevel already synchronised; slowTick one cycle per slow clock
// Notes: two slow cycles of edge delay after the filter
`timescale 1ns/1ps
`default_nettype none
`include "sda_defines.svh"

module pin_wakeup_filter
(
	input wire logic clock, // system clock
	input wire logic rstn, // synchronised reset, active low
	input wire logic clockEnable, // freezes state when low
	input wire logic slowTick, // slow clock edge pulse
	input wire logic pinLevel, // synchronised pin
	input wire sda_pkg::pin_cfg_type cfg, // edge and debounce select
	output logic wakePulse // one-cycle wake event
);

	logic [6:0] stableCnt_r;
	logic sample_r;
	logic filt_r;
	logic [1:0] delay_r;
	logic [6:0] stableNxt;
	logic [6:0] needLen;
	logic passLevel;
	logic edgeSeen;

	assign needLen = sda_pkg::debounce_len(cfg.debSel);
	assign stableNxt = (pinLevel != sample_r) ? `DEB_LEN0 :
		(stableCnt_r == `DEB_MAX) ? stableCnt_r : stableCnt_r + 7'h01;
	assign passLevel = stableNxt >= needLen;
	assign edgeSeen = sda_pkg::edge_hit(cfg.edgeSel, delay_r[1], delay_r[0]);

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			stableCnt_r <= `DEB_LEN0;
			sample_r <= 1'b0;
			filt_r <= 1'b0;
			delay_r <= 2'h0;
			wakePulse <= 1'b0;
		end
		else if (clockEnable)
		begin
			wakePulse <= slowTick && edgeSeen;
			if (slowTick)
			begin
				stableCnt_r <= stableNxt;
				sample_r <= pinLevel;
				filt_r <= passLevel ? pinLevel : filt_r;
				delay_r <= {delay_r[0], filt_r};
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	edge_off_a: assert property (cfg.edgeSel == `EDGE_OFF |=> !wakePulse)
		else $error("wake pulse with edge detection off");

endmodule

`default_nettype wire

// *** rtl/slow_domain_indirect_access.sv ***
// Purpose: indirect access port to watchdog, rtc wakeup timer and pin wakeup
// Assumes: slow clock arrives as a pin and is sampled on the system clock
// Notes: slow-domain work runs on slow clock edge pulses
`timescale 1ns/1ps
`default_nettype none
`include "sda_defines.svh"

module slow_domain_indirect_access
(
	input wire logic clock, // system clock, 200 MHz
	input wire logic resetn, // asynchronous reset, active low
	input wire logic clockEnable, // freezes all state except the reset release flops when low
	input wire logic [7:0] sfrAddr, // register address
	input wire logic sfrWrEn, // write strobe
	input wire logic [7:0] sfrWrData, // write data
	output logic [7:0] sfrRdData, // read data, one cycle after address
	input wire logic slowClockPin, // slow_32k_clock pin
	input wire logic [5:0] port0Pins, // port0_pin5..port0_pin0
	output logic watchdogReset, // system reset request
	output logic wakeupEvent, // pulse on any new wake status
	output logic [3:0] debounceTimer // debounce_timer_latch
);

	logic rstMeta_r;
	logic rstn;
	logic [6:0] pinSync;
	logic slowPrev_r;
	logic [7:0] tickCnt_r;
	logic [7:0] dataHi_r;
	logic [7:0] dataLo_r;
	sda_pkg::ctrl_type ctrl_r;
	sda_pkg::cmd_state_type cmdState_r;
	logic wdogActive_r;
	logic [15:0] wdogCnt_r;
	logic [23:0] rtcLatch_r;
	logic [23:0] rtcCnt_r;
	logic rtcEn_r;
	logic rtcWake_r;
	logic [5:0] pinWake_r;
	sda_pkg::pin_cfg_type [5:0] pinCfg_r;
	sda_pkg::pin_cfg_type [5:0] cfgNxt;
	logic [5:0] pinEvent;

	// reset release through two flops
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_r <= 1'b0;
			rstn <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstn <= rstMeta_r;
		end
	end

	sync_two_flop #(.WIDTH(7)) sync_two_flop_inst
	(
		.clock(clock),
		.rstn(rstn),
		.clockEnable(clockEnable),
		.asyncIn({slowClockPin, port0Pins}),
		.syncOut(pinSync)
	);

	// decode
	wire slowTick = clockEnable && pinSync[6] && !slowPrev_r;
	wire tickHit = slowTick && (tickCnt_r == `TICK_DIV);
	wire busy = cmdState_r == sda_pkg::CMD_PENDING;
	wire wrHi = clockEnable && sfrWrEn && (sfrAddr == `SFR_DATA_HI);
	wire wrLo = clockEnable && sfrWrEn && (sfrAddr == `SFR_DATA_LO);
	wire wrCtrl = clockEnable && sfrWrEn && (sfrAddr == `SFR_CTRL);
	wire accept = wrCtrl && !busy;
	wire execNow = busy && slowTick;
	wire execWr = execNow && ctrl_r.dir;
	wire execRd = execNow && !ctrl_r.dir;
	wire [15:0] dataWord = {dataHi_r, dataLo_r};
	wire atWdog = ctrl_r.addr == `IA_WDOG;
	wire atRtcUp = ctrl_r.addr == `IA_RTC_UP;
	wire atRtcLo = ctrl_r.addr == `IA_RTC_LO;
	wire atRtcCnt = ctrl_r.addr == `IA_RTC_CNT;
	wire atWakeA = ctrl_r.addr == `IA_WAKE_A;
	wire atWakeB = ctrl_r.addr == `IA_WAKE_B;
	wire statusRd = execRd && (atWakeA || atWakeB);
	wire rtcZero = rtcCnt_r == `RTC_INIT;
	wire rtcWakeSet = tickHit && rtcEn_r && rtcZero;
	wire [7:0] ctrlView = {3'h0, busy, ctrl_r.dir, ctrl_r.addr};

	// indirect read multiplexer
	wire [15:0] statusWord = {7'h00, rtcWake_r, 2'h0, pinWake_r};
	wire [15:0] rdWord =
		atWdog ? wdogCnt_r :
		atRtcUp ? {rtcCnt_r[23:16], rtcLatch_r[23:16]} :
		atRtcLo ? rtcLatch_r[15:0] :
		atRtcCnt ? rtcCnt_r[15:0] :
		(atWakeA || atWakeB) ? statusWord : 16'h0000;

	wire [7:0] sfrView =
		(sfrAddr == `SFR_DATA_HI) ? dataHi_r :
		(sfrAddr == `SFR_DATA_LO) ? dataLo_r :
		(sfrAddr == `SFR_CTRL) ? ctrlView : 8'h00;

	// pin configuration writes
	always_comb
	begin
		cfgNxt = pinCfg_r;
		if (execWr && atWakeA)
		begin
			for (int i = 0; i < 4; i++)
				cfgNxt[i] = dataWord[4*i +: 4];
		end
		if (execWr && atWakeB)
		begin
			cfgNxt[4] = dataWord[3:0];
			cfgNxt[5] = dataWord[7:4];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : pinFilters
			pin_wakeup_filter pin_wakeup_filter_inst
			(
				.clock(clock),
				.rstn(rstn),
				.clockEnable(clockEnable),
				.slowTick(slowTick),
				.pinLevel(pinSync[g]),
				.cfg(pinCfg_r[g]),
				.wakePulse(pinEvent[g])
			);
		end
	endgenerate

	// slow tick and command state
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			slowPrev_r <= 1'b0;
			tickCnt_r <= 8'h00;
			cmdState_r <= sda_pkg::CMD_IDLE;
			ctrl_r <= '0;
			sfrRdData <= 8'h00;
		end
		else if (clockEnable)
		begin
			slowPrev_r <= pinSync[6];
			sfrRdData <= sfrView;
			if (slowTick)
				tickCnt_r <= tickHit ? 8'h00 : tickCnt_r + 8'h01;
			if (accept)
			begin
				ctrl_r <= sda_pkg::ctrl_type'(sfrWrData[3:0]);
				cmdState_r <= sda_pkg::CMD_PENDING;
			end
			else if (execNow)
				cmdState_r <= sda_pkg::CMD_IDLE;
		end
	end

	// data register; processor write wins over a read result
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			dataHi_r <= `DATA_RESET;
			dataLo_r <= `DATA_RESET;
		end
		else
		begin
			if (wrHi)
				dataHi_r <= sfrWrData;
			else if (execRd)
				dataHi_r <= rdWord[15:8];
			if (wrLo)
				dataLo_r <= sfrWrData;
			else if (execRd)
				dataLo_r <= rdWord[7:0];
		end
	end

	// watchdog
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			wdogActive_r <= 1'b0;
			wdogCnt_r <= `WDOG_INIT;
			watchdogReset <= 1'b0;
		end
		else if (clockEnable)
		begin
			if (accept)
				wdogActive_r <= 1'b1;
			if (execWr && atWdog)
				wdogCnt_r <= dataWord;
			else if (tickHit && wdogActive_r && wdogCnt_r != 16'h0000)
				wdogCnt_r <= wdogCnt_r - 16'h0001;
			watchdogReset <= wdogActive_r && wdogCnt_r == 16'h0000;
		end
	end

	// rtc wakeup timer
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rtcLatch_r <= `RTC_INIT;
			rtcCnt_r <= `RTC_INIT;
			rtcEn_r <= 1'b0;
			debounceTimer <= 4'h0;
		end
		else if (clockEnable)
		begin
			if (execWr && atRtcUp)
			begin
				rtcLatch_r[23:16] <= dataLo_r;
				debounceTimer <= dataHi_r[3:0];
			end
			if (execWr && atRtcLo)
			begin
				rtcLatch_r[15:0] <= dataWord;
				rtcCnt_r <= {rtcLatch_r[23:16], dataWord};
				rtcEn_r <= 1'b1;
			end
			else if (execWr && atRtcCnt)
				rtcEn_r <= 1'b0;
			else if (tickHit && rtcEn_r)
				rtcCnt_r <= rtcZero ? rtcLatch_r : rtcCnt_r - 24'h000001;
		end
	end

	// wake status; a new event wins over clear-on-read
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rtcWake_r <= 1'b0;
			pinWake_r <= 6'h00;
			pinCfg_r <= '0;
			wakeupEvent <= 1'b0;
		end
		else if (clockEnable)
		begin
			pinCfg_r <= cfgNxt;
			rtcWake_r <= (rtcWake_r && !statusRd) || rtcWakeSet;
			pinWake_r <= (pinWake_r & {6{!statusRd}}) | pinEvent;
			wakeupEvent <= rtcWakeSet || (|pinEvent);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	busy_set_a: assert property (accept |=> busy && ctrlView[4])
		else $error("busy not set after control write");
	busy_clear_a: assert property (execNow |=> !busy)
		else $error("busy not cleared after execution");
	ctrl_unused_a: assert property (clockEnable && sfrAddr == `SFR_CTRL |=> sfrRdData[7:5] == 3'h0)
		else $error("unused control bits read nonzero");
	wdog_load_a: assert property (execWr && atWdog |=> wdogCnt_r == $past(dataWord))
		else $error("watchdog not loaded");
	wdog_sticky_a: assert property (wdogActive_r |=> wdogActive_r)
		else $error("watchdog stopped without reset");
	wdog_fire_a: assert property (clockEnable && wdogActive_r && wdogCnt_r == 16'h0000 |=> watchdogReset)
		else $error("watchdog expiry without reset request");
	rtc_reload_a: assert property (execWr && atRtcLo |=> rtcEn_r && rtcCnt_r[15:0] == $past(dataWord))
		else $error("rtc not reloaded by lower latch write");
	rtc_disable_a: assert property (execWr && atRtcCnt |=> !rtcEn_r)
		else $error("rtc not disabled");
	status_clear_a: assert property (statusRd && pinEvent == 6'h00 |=> pinWake_r == 6'h00)
		else $error("pin wake status not cleared on read");
	read_capture_a: assert property (execRd && atRtcCnt && !wrHi && !wrLo |=> dataWord == $past(rtcCnt_r[15:0]))
		else $error("rtc counter not captured");

	indirect_write_c: cover property (accept && sfrWrData[3] ##[1:1000] execWr);
	indirect_read_c: cover property (execRd && atWakeA ##1 !busy);
	wdog_fire_c: cover property (watchdogReset);
	rtc_wake_c: cover property (rtcWakeSet);

endmodule

`default_nettype wire

// *** tb/sfr_cpu_model.sv ***
// Purpose: processor side of the special function register bus
// Assumes: registered read data one edge after the address
// Notes: byte cycles only; sequences are built by the bench
`timescale 1ns/1ps
`default_nettype none

module sfr_cpu_model
(
	input wire logic clock, // system clock
	output logic [7:0] sfrAddr, // register address
	output logic sfrWrEn, // write strobe
	output logic [7:0] sfrWrData, // write data
	input wire logic [7:0] sfrRdData // read data
);
	initial
	begin
		sfrAddr = 8'h00;
		sfrWrEn = 1'b0;
		sfrWrData = 8'h00;
	end

	// one-cycle strobe; data turned over once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfrAddr <= a;
		sfrWrEn <= 1'b1;
		sfrWrData <= d;
		@(posedge clock);
		sfrWrEn <= 1'b0;
		sfrWrData <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		sfrAddr <= a;
		@(posedge clock);
		#1;
		d = sfrRdData;
	endtask
endmodule

`default_nettype wire

// *** tb/slow_domain_indirect_access_bench.sv ***
// Purpose: self-checking bench of the slow-domain indirect access block
// Assumes: slow clock pin runs free, faster than 32 kHz to keep the run short
// Notes: tick is four slow periods, 160 system clocks here
`timescale 1ns/1ps
`default_nettype none
`include "sda_defines.svh"

module slow_domain_indirect_access_bench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic slowClockPin = 1'b0;
	logic [5:0] port0Pins = 6'h00;
	logic clockEnable = 1'b1;
	logic [7:0] sfrAddr;
	logic [7:0] sfrWrData;
	logic [7:0] sfrRdData;
	logic sfrWrEn;
	logic watchdogReset;
	logic wakeupEvent;
	logic [3:0] debounceTimer;
	logic [7:0] b;
	logic [15:0] w;
	int err_total = 0;
	int checks_done = 0;

	always #2.5 clock = ~clock;
	always #100 slowClockPin = ~slowClockPin;

	slow_domain_indirect_access slow_domain_indirect_access_inst
	(
		.clock(clock),
		.resetn(resetn),
		.clockEnable(clockEnable),
		.sfrAddr(sfrAddr),
		.sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData),
		.slowClockPin(slowClockPin),
		.port0Pins(port0Pins),
		.watchdogReset(watchdogReset),
		.wakeupEvent(wakeupEvent),
		.debounceTimer(debounceTimer)
	);

	sfr_cpu_model sfr_cpu_model_inst
	(
		.clock(clock),
		.sfrAddr(sfrAddr),
		.sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData)
	);

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask

	task automatic wait_busy();
		logic [7:0] c;
		for (int i = 0; i < 200; i++)
		begin
			sfr_cpu_model_inst.rd(`SFR_CTRL, c);
			if (c[4] === 1'b0)
				return;
		end
		err_total++;
		$display("unexpected at %0t: busy stuck %h", $time, c);
		finish_test();
	endtask

	// sel 1 waits for the watchdog request, 0 for a wake pulse
	task automatic wait_out(input logic sel, input int bound);
		for (int i = 0; i < bound; i++)
		begin
			@(posedge clock);
			#1;
			if ((sel ? watchdogReset : wakeupEvent) === 1'b1)
				return;
		end
		err_total++;
		$display("unexpected at %0t: no output %h", $time, sel);
		finish_test();
	endtask

	task automatic ind_write(input logic [2:0] ia, input logic [15:0] d);
		sfr_cpu_model_inst.wr(`SFR_DATA_HI, d[15:8]);
		sfr_cpu_model_inst.wr(`SFR_DATA_LO, d[7:0]);
		sfr_cpu_model_inst.wr(`SFR_CTRL, {4'h0, 1'b1, ia});
		wait_busy();
	endtask

	task automatic ind_read(input logic [2:0] ia, output logic [15:0] d);
		sfr_cpu_model_inst.wr(`SFR_CTRL, {4'h0, 1'b0, ia});
		wait_busy();
		sfr_cpu_model_inst.rd(`SFR_DATA_HI, d[15:8]);
		sfr_cpu_model_inst.rd(`SFR_DATA_LO, d[7:0]);
	endtask

	task automatic t_reset();
		sfr_cpu_model_inst.rd(`SFR_DATA_HI, b);
		check_val({8'h00, b}, 16'h0000);
		sfr_cpu_model_inst.rd(`SFR_DATA_LO, b);
		check_val({8'h00, b}, 16'h0000);
		sfr_cpu_model_inst.rd(`SFR_CTRL, b);
		check_val({8'h00, b}, 16'h0000);
		sfr_cpu_model_inst.rd(8'h00, b);
		check_val({8'h00, b}, 16'h0000);
		check_val({15'h0000, watchdogReset}, 16'h0000);
	endtask

	task automatic t_data();
		sfr_cpu_model_inst.wr(`SFR_DATA_HI, 8'h5a);
		sfr_cpu_model_inst.wr(`SFR_DATA_LO, 8'hc3);
		sfr_cpu_model_inst.rd(`SFR_DATA_HI, b);
		check_val({8'h00, b}, 16'h005a);
		sfr_cpu_model_inst.rd(`SFR_DATA_LO, b);
		check_val({8'h00, b}, 16'h00c3);
	endtask

	// a write strobe while frozen must not land
	task automatic t_freeze();
		@(posedge clock);
		clockEnable <= 1'b0;
		sfr_cpu_model_inst.wr(`SFR_DATA_HI, 8'ha5);
		clockEnable <= 1'b1;
		sfr_cpu_model_inst.rd(`SFR_DATA_HI, b);
		check_val({8'h00, b}, 16'h005a);
	endtask

	task automatic t_wdog();
		// start just after a slow edge so busy is still seen
		@(posedge slowClockPin);
		sfr_cpu_model_inst.wr(`SFR_DATA_HI, 8'h12);
		sfr_cpu_model_inst.wr(`SFR_DATA_LO, 8'h34);
		sfr_cpu_model_inst.wr(`SFR_CTRL, 8'h08);
		sfr_cpu_model_inst.rd(`SFR_CTRL, b);
		check_val({8'h00, b}, 16'h0018);
		wait_busy();
		ind_read(3'h0, w);
		check_in(w, 16'h1232, 16'h1234);
	endtask

	task automatic t_rtc();
		logic [15:0] held;
		ind_write(3'h1, 16'hff07);
		check_val({12'h000, debounceTimer}, 16'h000f);
		ind_read(3'h1, w);
		check_val(w, 16'h0007);
		ind_write(3'h2, 16'h0003);
		ind_read(3'h1, w);
		check_val(w, 16'h0707);
		ind_read(3'h3, w);
		check_in(w, 16'h0000, 16'h0003);
		ind_read(3'h2, w);
		check_val(w, 16'h0003);
		ind_write(3'h3, 16'hffff);
		ind_read(3'h3, held);
		check_in(held, 16'h0000, 16'h0003);
		repeat (700) @(posedge clock);
		ind_read(3'h3, w);
		check_val(w, held);
		ind_read(3'h1, w);
		check_val(w, 16'h0707);
	endtask

	task automatic t_wake();
		ind_read(3'h4, w);
		check_val(w, 16'h0000);
		ind_write(3'h1, 16'h0000);
		check_val({12'h000, debounceTimer}, 16'h0000);
		ind_write(3'h2, 16'h0001);
		wait_out(1'b0, 1500);
		ind_write(3'h3, 16'h0000);
		ind_read(3'h4, w);
		check_val(w, 16'h0100);
		ind_read(3'h5, w);
		check_val(w, 16'h0000);
	endtask

	task automatic t_pins();
		ind_write(3'h5, 16'hff05);
		ind_write(3'h4, 16'h0008);
		@(posedge clock);
		port0Pins <= 6'h21;
		repeat (400) @(posedge clock);
		ind_read(3'h4, w);
		check_val(w, 16'h0000);
		@(posedge clock);
		port0Pins <= 6'h31;
		wait_out(1'b0, 2000);
		ind_read(3'h5, w);
		check_val(w, 16'h0010);
		@(posedge clock);
		port0Pins <= 6'h30;
		wait_out(1'b0, 2000);
		ind_read(3'h4, w);
		check_val(w, 16'h0001);
		// pin3 both edges no filter, pin2 rise 64, pin1 rise 8, pin0 kept
		ind_write(3'h4, 16'hc768);
		@(posedge clock);
		port0Pins <= 6'h3e;
		wait_out(1'b0, 2000);
		ind_read(3'h4, w);
		check_val(w, 16'h0008);
		wait_out(1'b0, 2000);
		ind_read(3'h4, w);
		check_val(w, 16'h0002);
		wait_out(1'b0, 4000);
		ind_read(3'h4, w);
		check_val(w, 16'h0004);
		@(posedge clock);
		port0Pins <= 6'h36;
		wait_out(1'b0, 2000);
		ind_read(3'h4, w);
		check_val(w, 16'h0008);
	endtask

	task automatic t_fire();
		ind_write(3'h0, 16'h0002);
		wait_out(1'b1, 1500);
		check_val({15'h0000, watchdogReset}, 16'h0001);
		ind_write(3'h0, 16'h1000);
		check_val({15'h0000, watchdogReset}, 16'h0000);
	endtask

	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_data();
		t_freeze();
		t_wdog();
		t_rtc();
		t_wake();
		t_pins();
		t_fire();
		finish_test();
	end
endmodule

`default_nettype wire
